//--- common/spb_pkg.sv
/*
 * Shared constants of the safety pause and brightness evaluation block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package spb_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_PAUSE  = 8'h04;
	localparam logic [7:0] OFF_BRIGHT = 8'h08;
	localparam logic [7:0] OFF_CAL_S  = 8'h0C;
	localparam logic [7:0] OFF_CAL_R  = 8'h10;
	localparam logic [7:0] OFF_TIMING = 8'h14;
	localparam logic [7:0] OFF_EXT    = 8'h18;
	localparam logic [7:0] OFF_FBACK  = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_ST = 8'h24;
	localparam logic [7:0] OFF_IRQ_MK = 8'h28;
	localparam logic [7:0] OFF_ASSOC  = 8'h2C;
	// Field positions
	localparam int CTRL_OBJ_POS   = 8;   // Object enables, 4 per block
	localparam int PAUSE_SEC_POS  = 8;   // Pause seconds above the 2-bit mode
	localparam int BR_WGT_POS     = 2;   // Weight in 5% steps
	localparam int BR_CORR_POS    = 7;
	localparam int BR_CYC_POS     = 8;
	localparam int BR_BASE_POS    = 9;
	localparam int BR_FACT_POS    = 16;
	localparam int HI_POS         = 16;  // Upper halfword of packed pairs
	// Sizes
	localparam int NUM_BLOCKS     = 5;
	localparam int OBJ_PER_BLOCK  = 4;
	localparam int GA_MAX         = 254;
	localparam int CONN_MAX       = 255;
	localparam int WGT_STEPS      = 20;  // 100% in 5% steps
	// Reset values
	localparam logic [4:0]  RST_BLK_EN  = 5'h01;
	localparam logic [19:0] RST_OBJ_EN  = 20'h00001;
	localparam logic [1:0]  RST_PMODE   = 2'h0;
	localparam logic [4:0]  RST_PSEC    = 5'h02;
	localparam logic [4:0]  PSEC_MIN    = 5'h01;
	localparam logic [4:0]  PSEC_MAX    = 5'h14;
	localparam logic [4:0]  RST_WGT     = 5'h0A;
	localparam logic [7:0]  RST_FACTOR  = 8'h1E;
	localparam logic [15:0] RST_S_OFF   = 16'h0032;
	localparam logic [15:0] RST_S_MAX   = 16'h0064;
	localparam logic [15:0] RST_R_OFF   = 16'h0064;
	localparam logic [15:0] RST_R_MAX   = 16'h015E;
	localparam logic [15:0] RST_THRESH  = 16'h0064;
	localparam logic [15:0] RST_STAIR   = 16'h003C;
	// Brightness sources and pause modes
	localparam logic [1:0] SRC_INT  = 2'h0;
	localparam logic [1:0] SRC_EXT  = 2'h1;
	localparam logic [1:0] SRC_BOTH = 2'h2;
	localparam logic [1:0] PM_OFF_ONLY = 2'h1;
	localparam logic [1:0] PM_ON_OFF   = 2'h2;
	// Timing: one second tick, cyclic time bases in seconds
	localparam int CLK_PERIOD_NS = 50;
	localparam int SECOND_NS     = 1000000000;
	localparam int TICK_CYC      = SECOND_NS / CLK_PERIOD_NS;
	localparam int BASE_MIN_S    = 60;
	localparam int BASE_HR_S     = 3600;
	// Interrupt bits
	localparam int IRQ_ON    = 0;
	localparam int IRQ_OFF   = 1;
	localparam int IRQ_PAUSE = 2;
	localparam int IRQ_LUX   = 3;
	// Per-block switching state
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ON = 2'b10} spb_blk_t;
endpackage

//--- core/spb_core.sv
/*
 * Movement detector general functions: common safety pause, brightness
 * source selection, weighting and correction, five movement blocks with
 * staircase timers, cyclic lux send, AXI4-Lite registers and interrupt.
 * Assumes movement and brightness pins are asynchronous; a bus stack
 * outside moves the object values to and from the bus.
 */
//
// Contract
// - Lighting goes on only on movement while brightness is below threshold.
// - Without movement the staircase timer runs and switches lighting off.
// - Five movement blocks, each with four individually enabled output objects.
// - Association store holds up to 254 addresses and 255 connections.
// - Minimum configuration: block one, object one only, single-bit output.
// - Output sends 1 at movement start and 0 when timer ran out.
// - A safety pause acts on all movement blocks together.
// - Feedback setting: no pause, pause on OFF, or pause on ON and OFF.
// - During a pause movement neither starts nor retriggers a timer.
// - A running timer is not disturbed by a pause starting.
// - Pause length is 1 to 20 seconds, default 2.
// - Brightness from internal sensor, external 2-byte object, or both.
// - Combined mode weights the separate value 0-100% in 5% steps, default 50.
// - Correction maps site brightness to reference area from four calibrations.
// - One brightness value serves all blocks and may be sent cyclically.
// - Cyclic period is time base (1 s, 1 min, 1 hr) times factor 1-255.
`timescale 1ns/1ps
module spb_core #(
	parameter int TICK_CYCLES = spb_pkg::TICK_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [4:0]  motion_in,
	input  wire logic [15:0] lux_int_in,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [19:0]      obj_val_out,
	output logic [19:0]      obj_send_out,
	output logic [15:0]      lux_out,
	output logic             lux_send_out,
	output logic             irq_out
);
	localparam int NB = spb_pkg::NUM_BLOCKS;

	// Byte-lane merge of a write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// Saturating clip of a count into 0..max
	function automatic logic [7:0] clip8(input logic [7:0] v, input int mx);
		clip8 = (int'(v) > mx) ? 8'(mx) : v;
	endfunction

	// Synchronisers for pins
	logic [4:0]  mot_s1_reg, mot_s2_reg;
	logic [15:0] lux_s1_reg, lux_s2_reg;
	always_ff @(posedge clk_in) begin
		mot_s1_reg <= motion_in;
		mot_s2_reg <= mot_s1_reg;
		lux_s1_reg <= lux_int_in;
		lux_s2_reg <= lux_s1_reg;
	end

	// Register file
	logic [31:0] ctrl_reg, pause_reg, bright_reg, cal_s_reg, cal_r_reg, timing_reg;
	logic [31:0] ext_reg, assoc_reg;
	logic [3:0]  irq_st_reg, irq_mk_reg, irq_ev;
	logic        fb_ev;
	logic        fb_val;

	wire [4:0]  blk_en   = ctrl_reg[4:0];
	wire [19:0] obj_en   = ctrl_reg[spb_pkg::CTRL_OBJ_POS +: 20];
	wire [1:0]  pmode    = pause_reg[1:0];
	wire [4:0]  psec     = pause_reg[spb_pkg::PAUSE_SEC_POS +: 5];
	wire [1:0]  src      = bright_reg[1:0];
	wire [4:0]  wgt      = bright_reg[spb_pkg::BR_WGT_POS +: 5];
	wire        corr_en  = bright_reg[spb_pkg::BR_CORR_POS];
	wire        cyc_en   = bright_reg[spb_pkg::BR_CYC_POS];
	wire [1:0]  tbase    = bright_reg[spb_pkg::BR_BASE_POS +: 2];
	wire [7:0]  factor   = bright_reg[spb_pkg::BR_FACT_POS +: 8];
	wire [15:0] thresh   = timing_reg[15:0];
	wire [15:0] stair_s  = timing_reg[spb_pkg::HI_POS +: 16];

	// AXI4-Lite write channel
	logic        aw_have_reg, w_have_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	wire         aw_hs   = s_axi_awvalid & s_axi_awready;
	wire         w_hs    = s_axi_wvalid & s_axi_wready;
	wire         aw_ok   = aw_have_reg | aw_hs;
	wire         w_ok    = w_have_reg | w_hs;
	wire         do_wr   = aw_ok & w_ok & ~s_axi_bvalid;
	wire [7:0]   wa      = aw_hs ? s_axi_awaddr : aw_addr_reg;
	wire [31:0]  wd      = w_hs ? s_axi_wdata : w_data_reg;
	wire [3:0]   ws      = w_hs ? s_axi_wstrb : w_strb_reg;
	wire         aw_have_next = aw_ok & ~do_wr;
	wire         w_have_next  = w_ok & ~do_wr;
	wire         bvalid_next  = do_wr | (s_axi_bvalid & ~s_axi_bready);
	wire         wa_known = (wa[1:0] == 2'h0) && (wa <= spb_pkg::OFF_ASSOC);
	wire         wr_ro    = (wa == spb_pkg::OFF_STATUS) || (wa == spb_pkg::OFF_IRQ_ST);
	wire         wr_any   = do_wr & wa_known & ~wr_ro;
	wire [31:0]  pause_wm = merge(pause_reg, wd, ws);
	wire [4:0]   psec_w   = pause_wm[spb_pkg::PAUSE_SEC_POS +: 5];
	wire [4:0]   psec_c   = (psec_w < spb_pkg::PSEC_MIN) ? spb_pkg::PSEC_MIN :
		(psec_w > spb_pkg::PSEC_MAX) ? spb_pkg::PSEC_MAX : psec_w;
	wire [31:0]  br_wm    = merge(bright_reg, wd, ws);
	wire [4:0]   wgt_c    = (br_wm[spb_pkg::BR_WGT_POS +: 5] > 5'(spb_pkg::WGT_STEPS)) ?
		5'(spb_pkg::WGT_STEPS) : br_wm[spb_pkg::BR_WGT_POS +: 5];
	wire [7:0]   fact_c   = (br_wm[spb_pkg::BR_FACT_POS +: 8] == 8'h00) ?
		8'h01 : br_wm[spb_pkg::BR_FACT_POS +: 8];
	wire [31:0]  as_wm    = merge(assoc_reg, wd, ws);
	wire [31:0]  ext_wm   = merge(ext_reg, wd, ws);
	wire [31:0]  mk_wm    = merge({28'h0, irq_mk_reg}, wd, ws);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			aw_have_reg   <= aw_have_next;
			w_have_reg    <= w_have_next;
			s_axi_awready <= ~aw_have_next & ~bvalid_next;
			s_axi_wready  <= ~w_have_next & ~bvalid_next;
			s_axi_bvalid  <= bvalid_next;
			if (do_wr) s_axi_bresp <= wa_known ? 2'h0 : 2'h2; // SLVERR when unmapped
		end
	end

	// Capture address and data held across cycles
	always_ff @(posedge clk_in) begin
		if (aw_hs) aw_addr_reg <= s_axi_awaddr;
		if (w_hs) begin
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
	end

	// Configuration registers; minimum configuration after reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ctrl_reg   <= {4'h0, spb_pkg::RST_OBJ_EN, 3'h0, spb_pkg::RST_BLK_EN};
			pause_reg  <= {19'h0, spb_pkg::RST_PSEC, 6'h0, spb_pkg::RST_PMODE};
			bright_reg <= {8'h0, spb_pkg::RST_FACTOR, 9'h0, spb_pkg::RST_WGT, spb_pkg::SRC_INT};
			cal_s_reg  <= {spb_pkg::RST_S_MAX, spb_pkg::RST_S_OFF};
			cal_r_reg  <= {spb_pkg::RST_R_MAX, spb_pkg::RST_R_OFF};
			timing_reg <= {spb_pkg::RST_STAIR, spb_pkg::RST_THRESH};
			ext_reg    <= 32'h0000_0000;
			assoc_reg  <= 32'h0000_0000;
			irq_mk_reg <= 4'h0;
		end else if (wr_any) begin
			unique case (wa)
				spb_pkg::OFF_CTRL:   ctrl_reg   <= merge(ctrl_reg, wd, ws) & 32'h0FFF_FF1F;
				spb_pkg::OFF_PAUSE:  pause_reg  <= {19'h0, psec_c, 6'h0, pause_wm[1:0]};
				spb_pkg::OFF_BRIGHT: bright_reg <= {8'h0, fact_c, 5'h0, br_wm[10:7], wgt_c,
					br_wm[1:0]};
				spb_pkg::OFF_CAL_S:  cal_s_reg  <= merge(cal_s_reg, wd, ws);
				spb_pkg::OFF_CAL_R:  cal_r_reg  <= merge(cal_r_reg, wd, ws);
				spb_pkg::OFF_TIMING: timing_reg <= merge(timing_reg, wd, ws);
				spb_pkg::OFF_EXT:    ext_reg    <= {16'h0, ext_wm[15:0]};
				spb_pkg::OFF_IRQ_MK: irq_mk_reg <= mk_wm[3:0];
				spb_pkg::OFF_ASSOC:  assoc_reg  <= {16'h0,
					clip8(as_wm[15:8], spb_pkg::CONN_MAX), clip8(as_wm[7:0], spb_pkg::GA_MAX)};
				default: ;
			endcase
		end
	end

	// Feedback object write is an event, value in bit 0
	assign fb_ev  = wr_any && (wa == spb_pkg::OFF_FBACK) && ws[0];
	assign fb_val = wd[0];

	// One-second tick divider
	logic [31:0] div_reg;
	logic        tick_reg;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			div_reg  <= 32'h0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (div_reg == 32'(TICK_CYCLES - 1));
			div_reg  <= (div_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : div_reg + 32'h1;
		end
	end

	// Common safety pause triggered by feedback
	logic [4:0] pcnt_reg;
	wire        pause_act = (pcnt_reg != 5'h0);
	wire        pause_go  = fb_ev && ((pmode == spb_pkg::PM_ON_OFF) ||
		((pmode == spb_pkg::PM_OFF_ONLY) && !fb_val));
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) pcnt_reg <= 5'h0;
		else if (pause_go) pcnt_reg <= psec;
		else if (tick_reg && pause_act) pcnt_reg <= pcnt_reg - 5'h1;
	end

	// Brightness selection, blend and correction
	wire [15:0] lux_i = lux_s2_reg;
	wire [15:0] lux_e = ext_reg[15:0];
	wire [21:0] mix   = 22'(lux_e * wgt) + 22'(lux_i * (5'(spb_pkg::WGT_STEPS) - wgt));
	wire [15:0] blend = 16'(mix / 22'(spb_pkg::WGT_STEPS));
	wire [15:0] site  = (src == spb_pkg::SRC_EXT) ? lux_e :
		(src == spb_pkg::SRC_BOTH) ? blend : lux_i;
	// Signed 48-bit: a site value below lamp-off goes negative and products stay exact
	wire signed [47:0] s_off = 48'(cal_s_reg[15:0]);
	wire signed [47:0] s_max = 48'(cal_s_reg[31:16]);
	wire signed [47:0] r_off = 48'(cal_r_reg[15:0]);
	wire signed [47:0] r_max = 48'(cal_r_reg[31:16]);
	wire signed [47:0] s_den = (s_max == s_off) ? 48'sd1 : (s_max - s_off);
	wire signed [47:0] corr  = r_off + (($signed(48'(site)) - s_off) * (r_max - r_off)) / s_den;
	wire [15:0] corr_c = (corr < 0) ? 16'h0 : (corr > 48'sd65535) ? 16'hFFFF : 16'(corr);
	wire [15:0] lux_next = corr_en ? corr_c : site;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) lux_out <= 16'h0;
		else lux_out <= lux_next;
	end

	// Cyclic lux transmission
	logic [19:0] cyc_reg;
	wire [19:0] base_s = (tbase == 2'h2) ? 20'(spb_pkg::BASE_HR_S) :
		(tbase == 2'h1) ? 20'(spb_pkg::BASE_MIN_S) : 20'h1;
	wire [19:0] period = 20'(base_s * factor);
	wire        cyc_hit = cyc_en && tick_reg && (cyc_reg >= period - 20'h1);
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !cyc_en) cyc_reg <= 20'h0;
		else if (tick_reg) cyc_reg <= cyc_hit ? 20'h0 : cyc_reg + 20'h1;
	end
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) lux_send_out <= 1'b0;
		else lux_send_out <= cyc_hit;
	end

	// Movement blocks with staircase timers
	spb_pkg::spb_blk_t st_reg [NB];
	logic [15:0]       tmr_reg [NB];
	logic [NB-1:0]     go_on, go_off;
	wire               dark = (lux_out < thresh);
	for (genvar b = 0; b < NB; b++) begin : g_blk
		wire mv = mot_s2_reg[b] & blk_en[b] & ~pause_act;
		assign go_on[b]  = (st_reg[b] == spb_pkg::ST_IDLE) & mv & dark;
		assign go_off[b] = (st_reg[b] == spb_pkg::ST_ON) & ~mv &
			(tmr_reg[b] == 16'h0);
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				st_reg[b]  <= spb_pkg::ST_IDLE;
				tmr_reg[b] <= 16'h0;
			end else begin
				unique case (st_reg[b])
					spb_pkg::ST_IDLE: if (go_on[b]) begin
						st_reg[b]  <= spb_pkg::ST_ON;
						tmr_reg[b] <= stair_s;
					end
					spb_pkg::ST_ON: if (mv) begin
						tmr_reg[b] <= stair_s;                          // Retrigger
					end else if (go_off[b] || (!blk_en[b] && tmr_reg[b] == 16'h0)) begin
						st_reg[b]  <= spb_pkg::ST_IDLE;
					end else if (tick_reg && tmr_reg[b] != 16'h0) begin
						tmr_reg[b] <= tmr_reg[b] - 16'h1;
					end
				endcase
			end
		end
		// Object sends: 1 on start, 0 on expiry, enabled objects only
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				obj_val_out[b*4 +: 4]  <= 4'h0;
				obj_send_out[b*4 +: 4] <= 4'h0;
			end else begin
				obj_send_out[b*4 +: 4] <= (go_on[b] | go_off[b]) ? obj_en[b*4 +: 4] : 4'h0;
				if (go_on[b]) obj_val_out[b*4 +: 4] <= 4'hF;
				else if (go_off[b]) obj_val_out[b*4 +: 4] <= 4'h0;
			end
		end
	end

	// Read channel and read-to-clear interrupt status
	wire        ar_hs = s_axi_arvalid & s_axi_arready;
	wire [7:0]  ra    = s_axi_araddr;
	wire        rd_clr = ar_hs && (ra == spb_pkg::OFF_IRQ_ST);
	logic [4:0] on_vec;
	always_comb begin
		for (int i = 0; i < NB; i++) on_vec[i] = (st_reg[i] == spb_pkg::ST_ON);
	end
	wire [31:0] rd_word =
		(ra == spb_pkg::OFF_CTRL)   ? ctrl_reg :
		(ra == spb_pkg::OFF_PAUSE)  ? pause_reg :
		(ra == spb_pkg::OFF_BRIGHT) ? bright_reg :
		(ra == spb_pkg::OFF_CAL_S)  ? cal_s_reg :
		(ra == spb_pkg::OFF_CAL_R)  ? cal_r_reg :
		(ra == spb_pkg::OFF_TIMING) ? timing_reg :
		(ra == spb_pkg::OFF_EXT)    ? ext_reg :
		(ra == spb_pkg::OFF_STATUS) ? {lux_out, 3'h0, pcnt_reg, 3'h0, on_vec} :
		(ra == spb_pkg::OFF_IRQ_ST) ? {28'h0, irq_st_reg} :
		(ra == spb_pkg::OFF_IRQ_MK) ? {28'h0, irq_mk_reg} :
		(ra == spb_pkg::OFF_ASSOC)  ? assoc_reg : 32'h0;
	wire ra_known = (ra[1:0] == 2'h0) && (ra <= spb_pkg::OFF_ASSOC);
	wire rvalid_next = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= ~rvalid_next;
			s_axi_rvalid  <= rvalid_next;
			if (ar_hs) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= ra_known ? 2'h0 : 2'h2;
			end
		end
	end

	// Sticky events, new events win over the read clear
	assign irq_ev = {cyc_hit, pause_go, |go_off, |go_on};
	wire [3:0] irq_next = (irq_st_reg & ~{4{rd_clr}}) | irq_ev;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq_st_reg <= 4'h0;
			irq_out    <= 1'b0;
		end else begin
			irq_st_reg <= irq_next;
			irq_out    <= |(irq_next & irq_mk_reg);
		end
	end

	// Checks
	on_needs_dark_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(on_vec[0]) |-> $past(dark && mot_s2_reg[0]))
		else $error("block on without dark movement");
	off_expiry_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$fell(on_vec[0]) |-> obj_val_out[0] == 1'b0 && obj_send_out[0] == obj_en[0])
		else $error("off send missing after expiry");
	on_sends_one_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(on_vec[0]) |-> obj_val_out[0] && obj_send_out[0] == obj_en[0])
		else $error("on send missing at start");
	pause_all_blocks_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		pause_act && on_vec == 5'h0 |=> on_vec == 5'h0)
		else $error("block started during pause");
	pause_no_retrig_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		pause_act && on_vec[0] |=> tmr_reg[0] <= $past(tmr_reg[0]))
		else $error("timer retriggered during pause");
	pause_keeps_on_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		pause_go && on_vec[0] && tmr_reg[0] > 16'h1 |=> on_vec[0])
		else $error("pause stopped running timer");
	pause_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		pause_go |=> pcnt_reg == $past(psec) && pcnt_reg >= 5'h1 && pcnt_reg <= 5'h14)
		else $error("pause length wrong");
	pause_mode_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		fb_ev && pmode == 2'h0 && !pause_act |=> !pause_act)
		else $error("pause started while disabled");
	blend_value_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		src == spb_pkg::SRC_BOTH && !corr_en && wgt == 5'h14 && $stable(ext_reg)
		|=> lux_out == $past(ext_reg[15:0]))
		else $error("full share not external");
	cyc_send_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		lux_send_out |-> $past(cyc_en && tick_reg))
		else $error("lux sent outside its period");
	cv_on_off_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(on_vec[0]) ##[1:1000] $fell(on_vec[0]));
	cv_pause_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		pause_go && on_vec[0]);
	cv_cyc_c: cover property (@(posedge clk_in) disable iff (sys_rst_in) lux_send_out);
endmodule // spb_core

//--- test/spb_act_model.sv
/*
 * Switch actuator model on the far side: takes the switch telegrams of
 * object one and holds the lamp state that it reports back as feedback.
 * Assumes the block's send pulses last one clock cycle.
 */
`timescale 1ns/1ps
module spb_act_model (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [19:0] obj_val_in,
	input  wire logic [19:0] obj_send_in,
	output logic             lamp_out
);
	// Lamp follows each telegram; its state is the status feedback value
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) lamp_out <= 1'b0;
		else if (obj_send_in[0]) lamp_out <= obj_val_in[0];
	end
endmodule // spb_act_model

//--- test/safety_pause_brightness_eval_tb_top.sv
/*
 * Self-checking bench: AXI4-Lite master tasks, random brightness cases,
 * pause, switching, interrupt and cyclic send checks.
 * Assumes the core runs with a 20-cycle second tick.
 */
`timescale 1ns/1ps
module safety_pause_brightness_eval_tb_top;
	localparam int TICK = 20;
	localparam logic [31:0] RV [6] = '{32'h0000_0101, 32'h0000_0200, 32'h001E_0028,
		32'h0064_0032, 32'h015E_0064, 32'h003C_0064};
	logic clk_in = 0, sys_rst_in = 1, lamp;
	logic [4:0] motion_in = '0;
	logic [15:0] lux_int_in = '0, lux_out;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, lux_send_out, irq_out;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [19:0] obj_val_out, obj_send_out;
	int bad_count = 0, samples_checked = 0, seed = 97, cyc;
	spb_core #(.TICK_CYCLES(TICK)) dut_u (.clk_in, .sys_rst_in, .motion_in, .lux_int_in,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .obj_val_out, .obj_send_out, .lux_out,
		.lux_send_out, .irq_out);
	spb_act_model act_u (.clk_in, .sys_rst_in, .obj_val_in(obj_val_out),
		.obj_send_in(obj_send_out), .lamp_out(lamp));
	// Clock, 50 ns period
	always #25 clk_in = ~clk_in;
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic hang();
		bad_count++;
		$display("[ERR] %0t wait ran out", $time);
		tally_and_finish();
	endtask
	// Write: both channels offered together, bready held until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_in);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		if (n == 40) hang();
		rs = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	// Read: rready held until rvalid, data taken at that edge
	task automatic rdr(input logic [7:0] a);
		int n;
		@(posedge clk_in);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_in);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		if (n == 40) hang();
		rd = s_axi_rdata; rs = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return obj_val_out[0];
			1: return obj_val_out[4];
			default: return lux_send_out;
		endcase
	endfunction
	// Bounded wait for an output level, cycles counted in cyc
	task automatic wt(input int s, input logic v, input int lim);
		for (cyc = 1; cyc <= lim; cyc++) begin
			@(posedge clk_in);
			#1;
			if (pick(s) === v) return;
		end
		hang();
	endtask
	function automatic logic [31:0] blend(input logic [31:0] e, i, w);
		return (e * w + i * (20 - w)) / 20;
	endfunction
	initial begin
		logic [31:0] e, i, w;
		int k, m, v;
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 0;
		repeat (2) @(posedge clk_in);
		// Reset values, clipping and unmapped places
		for (k = 0; k < 6; k++) begin
			rdr(8'(4 * k));
			chk(rd, RV[k], "reset value");
		end
		rdr(8'h31); chk(rs, 2'b10, "unaligned read");
		wr(8'h30, 32'h1); chk(rs, 2'b10, "unmapped write");
		wr(8'h2C, 32'hFFFF); rdr(8'h2C); chk(rd, 32'h0000_FFFE, "assoc clip");
		wr(8'h04, 32'h1F00); rdr(8'h04); chk(rd, 32'h0000_1400, "pause max");
		wr(8'h04, 32'h0000); rdr(8'h04); chk(rd, 32'h0000_0100, "pause min");
		wr(8'h08, 32'h007C); rdr(8'h08); chk(rd, 32'h0001_0050, "weight factor");
		// Random brightness sources and blend
		for (k = 0; k < 4; k++) begin
			e = $unsigned($random(seed)) & 32'hFFFF;
			i = $unsigned($random(seed)) & 32'hFFFF;
			w = (k == 0) ? 0 : (k == 1) ? 20 : $unsigned($random(seed)) % 21;
			lux_int_in <= i[15:0];
			wr(8'h18, e); wr(8'h08, 32'h001E_0001);
			repeat (6) @(posedge clk_in);
			chk(lux_out, e, "ext source");
			wr(8'h08, 32'h001E_0002 | (w << 2));
			repeat (6) @(posedge clk_in);
			chk(lux_out, blend(e, i, w), "blend");
			w = 50 + $unsigned($random(seed)) % 1000;
			lux_int_in <= w[15:0];
			wr(8'h08, 32'h001E_0080);
			repeat (6) @(posedge clk_in);
			chk(lux_out, 100 + (w - 50) * 5, "correction");
		end
		// Switch on, feedback starts a pause that covers all blocks
		wr(8'h08, 32'h001E_0028); wr(8'h14, 32'h0002_0064);
		wr(8'h04, 32'h1402); wr(8'h28, 32'h1);
		lux_int_in <= 16'h000A;
		repeat (6) @(posedge clk_in);
		motion_in <= 5'h03;
		wt(0, 1, 20); chk(obj_send_out[0], 1, "on send");
		repeat (2) @(posedge clk_in);
		chk(lamp, 1, "lamp on");
		wr(8'h1C, {31'h0, lamp});
		rdr(8'h20); chk(rd[12:8] > 18, 1, "pause length");
		wr(8'h00, 32'h1103);
		wt(0, 0, 100); chk(obj_val_out[4], 0, "other block");
		chk(irq_out, 1, "irq raised");
		rdr(8'h24); chk(rd[3:0], 4'h7, "irq status");
		repeat (3) @(posedge clk_in);
		chk(irq_out, 0, "irq cleared");
		wt(0, 1, 460);
		motion_in <= 5'h00;
		wt(0, 0, 120); chk(obj_send_out[0], 1, "off send");
		chk(cyc > TICK, 1, "timer ran");
		// Too bright: no switching
		lux_int_in <= 16'h00C8;
		repeat (6) @(posedge clk_in);
		motion_in <= 5'h01;
		repeat (60) @(posedge clk_in);
		chk(obj_val_out[0], 0, "bright gate");
		motion_in <= 5'h00;
		// Every feedback mode with both values
		for (m = 0; m < 3; m++) for (v = 0; v < 2; v++) begin
			wr(8'h04, 32'h0200 | m);
			wr(8'h1C, v);
			rdr(8'h20);
			chk(rd[12:8] != 0, (m == 2) || (m == 1 && v == 0), "pause mode");
			repeat (3 * TICK) @(posedge clk_in);
		end
		// Cyclic lux send period, factor 2 on the 1 s base
		wr(8'h08, 32'h0002_0128);
		wt(2, 1, 200); wt(2, 0, 5); wt(2, 1, 200);
		chk(1 + cyc, 2 * TICK, "cyclic period");
		chk(lux_out, 32'd200, "shared lux");
		// Minute base, factor 1
		wr(8'h08, 32'h0001_0328);
		wt(2, 1, 1300); wt(2, 0, 5); wt(2, 1, 1300);
		chk(1 + cyc, 60 * TICK, "minute period");
		tally_and_finish();
	end
endmodule // safety_pause_brightness_eval_tb_top
